// ===== core/zei2c_defs.vh
// constants for the zoned eeprom two-wire target
`ifndef ZEI2C_DEFS_VH
`define ZEI2C_DEFS_VH
`define ZEI_DEV_NIBBLE 4'hb
`define ZEI_ZONE_CFG 2'h3
`define ZEI_OFS_W 6
`define ZEI_ZONE_BYTES 64
`define ZEI_MEM_BYTES 256
`define ZEI_PAGE_BYTES 4'h8
`define ZEI_OFS_MAKER 6'h08
`define ZEI_OFS_CUST 6'h0a
`define ZEI_OFS_SERIAL 6'h19
`define ZEI_OFS_SERIAL_END 6'h1e
`define ZEI_FIFO_DEPTH 16
`define ZEI_FIFO_WIDTH 16
`endif

// ===== core/zei2c_target.v
// two-wire zoned eeprom target with write page fifo
//
// Summary of operation
// RULE_01: host keeps the spare control input low during all traffic.
// RULE_02: spare control input is pulled low inside, open pin acts low.
// RULE_03: storage is 2,048 bits, four zones of 64 bytes, byte offset.
// RULE_04: zones 0-2 read/write; zone 3 holds maker, customer, serial.
// RULE_05: maker code at 0x08, customer code next, serial 0x19 to 0x1e.
// RULE_06: read command byte is 1011, zone bits, 0, then 1.
// RULE_07: zone bits 00,01,10 select zones 0-2; 11 selects config.
// RULE_08: read zone from command, offset from next byte, no dummy write.
// RULE_09: read: start, command, ack, offset, ack, then data bytes.
// RULE_10: host acks each read byte but the last, then nack and stop.
// RULE_11: serial read from 0x19 returns six bytes msb first, advancing.
// RULE_12: four-byte read at config 0x08 gives maker then customer code.
// RULE_13: write command byte is 1011, zone bits, 0, then 0.
// RULE_14: write offset byte follows command; data bytes follow offset.
// RULE_15: host writes only zones 0-2, never the config zone.
// RULE_16: write data is gathered in an 8-byte page before storing.
// RULE_17: host sends at most 8 data bytes per write.
// RULE_18: wrong device nibble gets no ack; bus released until next start.
`timescale 1ns/100ps
`include "zei2c_defs.vh"

module zei_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock_i,
	input wire resetn_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

module zei_target #(
	parameter [15:0] MAKER_CODE = 16'h1234, // arbitrary value
	parameter [15:0] CUSTOMER_CODE = 16'h5678, // arbitrary value
	parameter [47:0] SERIAL_NUMBER = 48'h0a0b0c0d0e0f // arbitrary value
) (
	input wire clock_i,
	input wire resetn_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	input wire spare_ctl_i,
	output reg spare_pulldown_o,
	output reg commit_busy_o
);
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_CMD = 9'h002;
	localparam [8:0] S_CACK = 9'h004;
	localparam [8:0] S_OFS = 9'h008;
	localparam [8:0] S_OACK = 9'h010;
	localparam [8:0] S_WDAT = 9'h020;
	localparam [8:0] S_WACK = 9'h040;
	localparam [8:0] S_RDAT = 9'h080;
	localparam [8:0] S_RACK = 9'h100;

	reg [7:0] mem_q [0:`ZEI_MEM_BYTES-1]; // [RULE_03]
	reg [2:0] scl_s_q;
	reg [2:0] sda_s_q;
	reg [1:0] spare_s_q;
	reg [8:0] state_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg [1:0] zone_q;
	reg rd_q;
	reg [5:0] ofs_q;
	reg [3:0] page_q;
	reg hack_q;
	reg push_q;
	reg [15:0] push_data_q;
	reg drain_q;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire fifo_ready;
	wire [15:0] fifo_out;
	wire fifo_valid;
	wire [7:0] rd_byte;

	// config zone bytes are fixed, other zones come from the array
	function [7:0] cfg_byte;
		input [5:0] ofs;
		begin
			case (ofs) // [RULE_05]
				`ZEI_OFS_MAKER: cfg_byte = MAKER_CODE[15:8]; // [RULE_12]
				`ZEI_OFS_MAKER + 6'h1: cfg_byte = MAKER_CODE[7:0];
				`ZEI_OFS_CUST: cfg_byte = CUSTOMER_CODE[15:8];
				`ZEI_OFS_CUST + 6'h1: cfg_byte = CUSTOMER_CODE[7:0];
				`ZEI_OFS_SERIAL: cfg_byte = SERIAL_NUMBER[47:40]; // [RULE_11]
				`ZEI_OFS_SERIAL + 6'h1: cfg_byte = SERIAL_NUMBER[39:32];
				`ZEI_OFS_SERIAL + 6'h2: cfg_byte = SERIAL_NUMBER[31:24];
				`ZEI_OFS_SERIAL + 6'h3: cfg_byte = SERIAL_NUMBER[23:16];
				`ZEI_OFS_SERIAL + 6'h4: cfg_byte = SERIAL_NUMBER[15:8];
				`ZEI_OFS_SERIAL_END: cfg_byte = SERIAL_NUMBER[7:0];
				default: cfg_byte = 8'hff;
			endcase
		end
	endfunction

	// zone select 11 maps to config, others to user array
	assign rd_byte = (zone_q == `ZEI_ZONE_CFG) ? cfg_byte(ofs_q) :
		mem_q[{zone_q, ofs_q}]; // [RULE_04] [RULE_07]

	assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
	assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
	assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

	zei_fifo #(
		.WIDTH(`ZEI_FIFO_WIDTH),
		.DEPTH(`ZEI_FIFO_DEPTH),
		.AW(4)
	) zei_fifo_inst (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.in_data_i(push_data_q),
		.in_valid_i(push_q),
		.in_ready_o(fifo_ready),
		.out_data_o(fifo_out),
		.out_valid_o(fifo_valid),
		.out_ready_i(drain_q)
	);

	// committed page bytes land in user zones only
	always @(posedge clock_i) begin
		if (fifo_valid && drain_q && fifo_out[15:14] != `ZEI_ZONE_CFG) begin
			mem_q[fifo_out[15:8]] <= fifo_out[7:0]; // [RULE_16]
		end
	end

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			spare_s_q <= 2'h0;
			spare_pulldown_o <= 1'b1;
			commit_busy_o <= 1'b0;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			spare_s_q <= {spare_s_q[0], spare_ctl_i};
			spare_pulldown_o <= 1'b1; // [RULE_02]
			commit_busy_o <= drain_q | push_q | fifo_valid;
		end
	end

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			zone_q <= 2'h0;
			rd_q <= 1'b0;
			ofs_q <= 6'h00;
			page_q <= 4'h0;
			hack_q <= 1'b0;
			push_q <= 1'b0;
			push_data_q <= 16'h0000;
			drain_q <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			push_q <= 1'b0;
			sda_o <= 1'b0;
			if (drain_q && !fifo_valid && !push_q) begin
				drain_q <= 1'b0;
			end
			if (spare_s_q[1]) begin
				state_q <= S_IDLE;
				sda_oe_o <= 1'b0;
			end else if (stop_det) begin
				state_q <= S_IDLE;
				sda_oe_o <= 1'b0;
				if (page_q != 4'h0) begin
					drain_q <= 1'b1; // [RULE_16]
				end
				page_q <= 4'h0;
			end else if (start_det) begin
				state_q <= S_CMD;
				cnt_q <= 4'h0;
				sda_oe_o <= 1'b0;
				if (page_q != 4'h0) begin
					drain_q <= 1'b1;
				end
				page_q <= 4'h0;
			end else begin
				case (state_q)
					S_CMD, S_OFS, S_WDAT: begin
						if (scl_rise) begin
							sh_q <= {sh_q[6:0], sda_s_q[1]};
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == 4'h8) begin
							cnt_q <= 4'h0;
							if (state_q == S_CMD) begin
								// [RULE_06] [RULE_13] [RULE_18]
								if (sh_q[7:4] == `ZEI_DEV_NIBBLE &&
									!sh_q[1]) begin
									zone_q <= sh_q[3:2]; // [RULE_07] [RULE_08]
									rd_q <= sh_q[0];
									sda_oe_o <= 1'b1; // [RULE_09]
									state_q <= S_CACK;
								end else begin
									state_q <= S_IDLE;
								end
							end else if (state_q == S_OFS) begin
								ofs_q <= sh_q[5:0]; // [RULE_08] [RULE_14]
								sda_oe_o <= 1'b1; // [RULE_09]
								state_q <= S_OACK;
							end else if (page_q != `ZEI_PAGE_BYTES &&
								fifo_ready) begin
								push_q <= 1'b1; // [RULE_14] [RULE_16]
								push_data_q <= {zone_q, ofs_q, sh_q};
								ofs_q <= {ofs_q[5:3], ofs_q[2:0] + 3'h1};
								page_q <= page_q + 4'h1;
								sda_oe_o <= 1'b1;
								state_q <= S_WACK;
							end else begin
								state_q <= S_IDLE;
							end
						end
					end
					S_CACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							state_q <= S_OFS;
						end
					end
					S_OACK, S_RACK: begin
						if (scl_rise) begin
							hack_q <= ~sda_s_q[1];
						end
						if (scl_fall) begin
							if ((state_q == S_OACK && rd_q) ||
								(state_q == S_RACK && hack_q)) begin
								// [RULE_11] [RULE_12]
								sh_q <= {rd_byte[6:0], 1'b0};
								sda_oe_o <= ~rd_byte[7];
								ofs_q <= ofs_q + 6'h1;
								cnt_q <= 4'h1;
								state_q <= S_RDAT;
							end else if (state_q == S_OACK) begin
								sda_oe_o <= 1'b0;
								state_q <= S_WDAT;
							end else begin
								sda_oe_o <= 1'b0;
								state_q <= S_IDLE;
							end
						end
					end
					S_WACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							state_q <= S_WDAT;
						end
					end
					S_RDAT: begin
						if (scl_fall) begin
							if (cnt_q == 4'h8) begin
								sda_oe_o <= 1'b0;
								hack_q <= 1'b0;
								state_q <= S_RACK;
							end else begin
								sda_oe_o <= ~sh_q[7];
								sh_q <= {sh_q[6:0], 1'b0};
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					S_IDLE: begin
						sda_oe_o <= 1'b0;
					end
					default: begin
						state_q <= S_IDLE;
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule

// ===== tb/zei_host.sv
// behavioural bus controller for the target
`timescale 1ns/100ps
module zei_host (
	input wire clock_i,
	input wire sda_i,
	output reg scl_o,
	output reg pull_o
);
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task q;
		begin
			repeat (2) @(posedge clock_i);
			#1;
		end
	endtask
	task bitx(input b, output r);
		begin
			scl_o = 1'b0;
			q;
			pull_o = !b;
			q;
			scl_o = 1'b1;
			q;
			r = sda_i;
			q;
		end
	endtask
	// byte msb first, then ninth bit
	task xbyte(input [7:0] d, input an, output [7:0] r, output ak);
		reg a;
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(d[i], r[i]);
			bitx(an, a);
			ak = !a;
		end
	endtask
	task start;
		begin
			pull_o = 1'b1;
			q;
		end
	endtask
	task stop;
		begin
			scl_o = 1'b0;
			q;
			pull_o = 1'b1;
			q;
			scl_o = 1'b1;
			q;
			pull_o = 1'b0;
			q;
		end
	endtask
endmodule

// ===== tb/zei_target_properties.sv
// port assertions for the two-wire target
`timescale 1ns/100ps
module zei_target_properties (
	input wire clock_i,
	input wire resetn_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_o,
	input wire spare_ctl_i,
	input wire spare_pulldown_o,
	input wire commit_busy_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	a_pulldown_on: assert property (spare_pulldown_o)
		else $error("pull-down off");
	a_drive_low_only: assert property (!sda_o)
		else $error("data driven high");
	a_oe_scl_low: assert property (
		$changed(sda_oe_o) |-> !scl_i) else $error("oe moved, scl high");
	a_oe_holds_high: assert property (
		$rose(scl_i) |-> $stable(sda_oe_o)[*3])
		else $error("oe moved in scl high");
	a_start_released: assert property (
		$fell(sda_i) && scl_i |-> !sda_oe_o) else $error("driving at start");
	a_stop_released: assert property (
		$rose(sda_i) && scl_i |-> !sda_oe_o) else $error("driving at stop");
	a_reset_quiet: assert property (
		$rose(resetn_i) |-> !sda_oe_o && !commit_busy_o)
		else $error("busy after reset");
	a_busy_idle: assert property (
		$fell(commit_busy_o) |-> scl_i && sda_i)
		else $error("commit ended mid frame");
endmodule
bind zei_target zei_target_properties zei_target_properties_inst (
	.clock_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .spare_ctl_i,
	.spare_pulldown_o, .commit_busy_o);

// ===== tb/zei_target_tb.sv
// self-checking bench for the two-wire target
`timescale 1ns/100ps
module zei_target_tb;
	reg clock_i = 1'b0;
	reg resetn_i = 1'b0;
	reg spare = 1'b0;
	wire scl, pull, sda_o, sda_oe_o, pd, busy;
	wire sda = !(pull || sda_oe_o);
	reg [7:0] bf [0:7];
	reg [7:0] r;
	reg ak;
	integer fail_count = 0;
	integer checks_done = 0;
	always #5 clock_i = !clock_i;
	zei_host zei_host_inst (.clock_i, .sda_i(sda), .scl_o(scl),
		.pull_o(pull));
	zei_target zei_target_inst (.clock_i, .resetn_i, .scl_i(scl),
		.sda_i(sda), .sda_o, .sda_oe_o, .spare_ctl_i(spare),
		.spare_pulldown_o(pd), .commit_busy_o(busy));
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("ERROR %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wait_idle;
		integer k;
		begin
			for (k = 0; busy !== 1'b0; k = k + 1) begin
				if (k == 100) begin
					fail_count = fail_count + 1;
					$display("ERROR commit_busy_o exp 0 got %b", busy);
					complete_run;
				end
				@(posedge clock_i);
			end
		end
	endtask
	task xfer(input [7:0] cmd, input [7:0] ofs, input integer n);
		integer i;
		begin
			zei_host_inst.start;
			zei_host_inst.xbyte(cmd, 1'b1, r, ak);
			chk("cmd ack", 8'h01, {7'h00, ak});
			zei_host_inst.xbyte(ofs, 1'b1, r, ak);
			chk("ofs ack", 8'h01, {7'h00, ak});
			for (i = 0; i < n; i = i + 1) begin
				if (cmd[0]) begin
					zei_host_inst.xbyte(8'hff, i == n - 1, bf[i], ak);
				end else begin
					zei_host_inst.xbyte(bf[i], 1'b1, r, ak);
					chk("data ack", 8'h01, {7'h00, ak});
				end
			end
			zei_host_inst.stop;
			wait_idle;
		end
	endtask
	task t_zones;
		integer z, i;
		begin
			for (z = 0; z < 3; z = z + 1) begin
				for (i = 0; i < 8; i = i + 1)
					bf[i] = 8'(i * 29 + z * 64);
				xfer({4'hb, 2'(z), 2'h0}, 8'h38, 8);
			end
			for (z = 0; z < 3; z = z + 1) begin
				xfer({4'hb, 2'(z), 2'h1}, 8'h38, 8);
				for (i = 0; i < 8; i = i + 1)
					chk("zone", 8'(i * 29 + z * 64), bf[i]);
			end
			$display("zones done");
		end
	endtask
	task t_config;
		reg [47:0] s;
		integer i;
		begin
			s = 48'h0a0b0c0d0e0f;
			xfer(8'hbd, 8'h19, 6);
			for (i = 0; i < 6; i = i + 1)
				chk("serial", s[8 * (5 - i) +: 8], bf[i]);
			s = 48'h12345678;
			xfer(8'hbd, 8'h08, 4);
			for (i = 0; i < 4; i = i + 1)
				chk("codes", s[8 * (3 - i) +: 8], bf[i]);
			$display("config done");
		end
	endtask
	task t_bad;
		begin
			zei_host_inst.start;
			zei_host_inst.xbyte(8'h75, 1'b1, r, ak);
			chk("bad ack", 8'h00, {7'h00, ak});
			zei_host_inst.xbyte(8'hb5, 1'b1, r, ak);
			chk("late ack", 8'h00, {7'h00, ak});
			zei_host_inst.stop;
			zei_host_inst.start;
			zei_host_inst.xbyte(8'hbf, 1'b1, r, ak);
			chk("bit1 ack", 8'h00, {7'h00, ak});
			zei_host_inst.stop;
			$display("bad done");
		end
	endtask
	task t_spare;
		begin
			spare = 1'b1;
			repeat (3) @(posedge clock_i);
			#1;
			chk("pull-down", 8'h01, {7'h00, pd});
			chk("sda_o", 8'h00, {7'h00, sda_o});
			zei_host_inst.start;
			zei_host_inst.xbyte(8'hbd, 1'b1, r, ak);
			chk("spare ack", 8'h00, {7'h00, ak});
			zei_host_inst.stop;
			spare = 1'b0;
			repeat (3) @(posedge clock_i);
			#1;
			xfer(8'hbd, 8'h08, 1);
			chk("codes", 8'h12, bf[0]);
			$display("spare done");
		end
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		#1;
		resetn_i = 1'b1;
		repeat (4) @(posedge clock_i);
		t_zones;
		t_config;
		t_bad;
		t_spare;
		complete_run;
	end
endmodule
